/* File: rslog_pkg.sv */
// rslog_pkg: addresses, fields, sizes, timing and types of the result logger
package rslog_pkg;
  localparam int PTS = 16;
  localparam int ENV_N = 16;
  localparam int ACQ_W = 20;
  localparam logic [4:0] PTS_MAX = 5'h10;
  localparam logic [4:0] LEN_RST = 5'h01;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int DLY_RES_NS = 2;
  localparam logic [24:0] DLY_STEP = 25'(CLK_NS / DLY_RES_NS);
  localparam logic [25:0] INT_LEN_MAX = 26'h200_0000;
  localparam logic [25:0] INT_LEN_MIN = 26'h000_0001;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [11:0] A_RO_CTRL = 12'h000;
  localparam logic [11:0] A_RO_LEN = 12'h004;
  localparam logic [11:0] A_RO_CLR = 12'h008;
  localparam logic [11:0] A_RO_ERR = 12'h00C;
  localparam logic [11:0] A_RO_JOB = 12'h010;
  localparam logic [11:0] A_RO_ACQ = 12'h014;
  localparam logic [11:0] A_RO_OVD = 12'h018;
  localparam logic [11:0] A_SP_CTRL = 12'h01C;
  localparam logic [11:0] A_SP_LEN = 12'h020;
  localparam logic [11:0] A_SP_CLR = 12'h024;
  localparam logic [11:0] A_SP_ERR = 12'h028;
  localparam logic [11:0] A_SP_JOB = 12'h02C;
  localparam logic [11:0] A_SP_ACQ = 12'h030;
  localparam logic [11:0] A_SP_DLY = 12'h034;
  localparam logic [11:0] A_ENV_DLY = 12'h038;
  localparam logic [11:0] A_INT_LEN = 12'h03C;
  localparam logic [11:0] A_ENV_LEN = 12'h040;
  localparam logic [11:0] A_ENV_WAVE = 12'h044;
  localparam logic [11:0] A_ENV_LOAD = 12'h048;
  localparam logic [11:0] A_PSD_CLR = 12'h04C;
  localparam logic [11:0] A_PSD_OVF = 12'h050;
  localparam logic [11:0] A_RO_DATA = 12'h100;
  localparam logic [11:0] A_SP_DATA = 12'h140;
  // ---------------------------------------------------------------
  // fields and codes
  // ---------------------------------------------------------------
  localparam int F_EN = 0;
  localparam int F_MODE = 1;
  localparam int F_SRC = 2;
  localparam int F_ENV = 2;
  localparam int F_PSD = 3;
  localparam int F_AVG = 8;
  localparam logic [1:0] SRC_WSUM = 2'h1;
  localparam logic [1:0] SRC_STATE = 2'h3;
  typedef struct packed {
    logic en;
    logic mode;
    logic [3:0] avg_exp;
    logic [4:0] len;
  } rslog_lcfg_t;
  typedef struct packed {
    logic [ACQ_W-1:0] acq;
    logic [15:0] err;
    logic [ACQ_W-1:0] job;
  } rslog_lsta_t;
  typedef enum logic [2:0] {SP_IDLE = 3'h1, SP_DLY = 3'h2, SP_INT = 3'h4} rslog_spst_t;
endpackage

/* File: rslog_src.sv */
// rslog_src: trigger source and result producer model of the readout path
module rslog_src (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  output logic ro_trig,
  output logic ro_vld
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] sh_ff;
  // ---------------------------------------------------------------
  // trigger, then result three cycles later
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sh_ff <= 4'h0;
    else sh_ff <= {sh_ff[2:0], go};
  end
  // a second go one cycle late lands its trigger inside the busy window
  assign ro_trig = sh_ff[0];
  assign ro_vld = sh_ff[3];
endmodule // rslog_src

/* File: rslog_tb_top.sv */
// rslog_tb_top: self-checking bench of the result logger
module rslog_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rslog_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
  logic dio_rdy = 1, sp_trig = 0, ro_trig, ro_vld, dio_vld, pready, pslverr, err_s;
  logic vld_d = 0, exp_dio = 0, busy_m = 0, ro_en_m = 0, ce = 1;
  int ro_cnt_m = 0, ro_len_m = 1;
  logic [31:0] seq_d [4];
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, dio_data, wsum = 0, sdec = 0, seed, v;
  logic signed [15:0] sp_i = 0, sp_q = 0, osc_i = 0, osc_q = 0, env_i, env_q;
  int num_errors = 0, check_count = 0;
  rslog_top u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ro_trig(ro_trig), .ro_vld(ro_vld),
    .weighted_sum_source(wsum), .state_decision_source(sdec), .dio_rdy(dio_rdy),
    .dio_vld(dio_vld), .dio_data(dio_data), .sp_trig(sp_trig), .sp_i(sp_i), .sp_q(sp_q),
    .osc_i(osc_i), .osc_q(osc_q), .env_i(env_i), .env_q(env_q));
  rslog_src u_src (.pclk(pclk), .presetn(presetn), .go(go), .ro_trig(ro_trig),
    .ro_vld(ro_vld));
  initial begin
    forever #5 pclk = ~pclk;
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // mean of two packed {i,q} results, halves kept apart
  function automatic logic [31:0] avg2(input logic [31:0] a, input logic [31:0] b);
    logic signed [31:0] si, sq;
    si = ($signed(a[31:16]) + $signed(b[31:16])) >>> 1;
    sq = ($signed(a[15:0]) + $signed(b[15:0])) >>> 1;
    return {si[15:0], sq[15:0]};
  endfunction
  // real part of oscillator times envelope, q1.15, with a zero q oscillator
  function automatic logic [31:0] mod_re(input logic signed [15:0] o, input logic [31:0] w);
    logic signed [31:0] p;
    p = o * $signed(w[31:16]);
    return 32'($signed(p[30:15]));
  endfunction
  // power sum of n equal samples on i and q, upper word as logged
  function automatic logic [31:0] psd_exp(input int n, input int s);
    logic [63:0] p;
    p = 64'(n) * 64'(2 * s * s);
    return {16'h0000, p[47:32]};
  endfunction
  task automatic report_and_stop();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    v = prdata;
    err_s = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
    if (n >= 50) begin
      num_errors++;
      report_and_stop();
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 32'h0000_0000);
    chk(v, e);
  endtask
  task automatic pulse(input int gap);
    go <= 1;
    @(posedge pclk);
    go <= 0;
    repeat (gap) @(posedge pclk);
  endtask
  // bench model of the readout logger: busy from an accepted trigger to its result
  always @(posedge pclk) begin
    if (vld_d) chk(32'(dio_vld), 32'(exp_dio));
    vld_d <= ro_vld;
    if (ce) begin
      exp_dio <= ro_vld && busy_m && dio_rdy;
      if (!ro_en_m) begin
        busy_m <= 0;
        ro_cnt_m <= 0;
      end else if (ro_trig && !busy_m && ro_cnt_m < ro_len_m) begin
        busy_m <= 1;
        ro_cnt_m <= ro_cnt_m + 1;
      end else if (ro_vld && busy_m) begin
        busy_m <= 0;
      end
    end
  end
  initial begin
    #400000;
    num_errors++;
    report_and_stop();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 32'h49e7_5882;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(A_RO_CTRL, 32'h0000_0004);
    rd(A_RO_LEN, 32'h0000_0001);
    apb(0, 12'h0FC, 32'h0000_0000);
    chk(32'(err_s), 32'h1);
    pulse(8);
    rd(A_RO_ACQ, 32'h0000_0000);
    apb(1, A_RO_CTRL, 32'h0000_0005);
    apb(1, A_RO_LEN, 32'h0000_0002);
    ro_en_m <= 1;
    ro_len_m <= 2;
    seed = xs(seed);
    wsum <= seed;
    sdec <= ~seed;
    pulse(8);
    rd(A_RO_DATA, seed);
    rd(A_RO_ACQ, 32'h0000_0001);
    apb(1, A_RO_CTRL, 32'h0000_000D);
    dio_rdy <= 0;
    pulse(8);
    rd(A_RO_DATA + 12'h004, ~seed);
    rd(A_RO_OVD, 32'h0000_0001);
    dio_rdy <= 1;
    pulse(8);
    rd(A_RO_ACQ, 32'h0000_0002);
    apb(1, A_RO_CTRL, 32'h0000_0000);
    ro_en_m <= 0;
    apb(1, A_RO_CTRL, 32'h0000_0005);
    ro_en_m <= 1;
    go <= 1;
    @(posedge pclk);
    pulse(8);
    rd(A_RO_ERR, 32'h0000_0001);
    rd(A_RO_JOB, 32'h0000_0000);
    // a trigger while the clock enable is low must leave the index alone
    ce <= 0;
    pulse(8);
    ce <= 1;
    rd(A_RO_ACQ, 32'h0000_0001);
    apb(1, A_RO_CLR, xs(seed));
    rd(A_RO_ERR, 32'h0000_0000);
    apb(1, A_RO_CTRL, 32'h0000_0000);
    ro_en_m <= 0;
    apb(1, A_RO_CTRL, 32'h0000_0107);
    ro_en_m <= 1;
    ro_len_m <= 4;
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      seq_d[k] = seed;
      wsum <= seed;
      pulse(8);
    end
    rd(A_RO_DATA, avg2(seq_d[0], seq_d[1]));
    rd(A_RO_DATA + 12'h004, avg2(seq_d[2], seq_d[3]));
    apb(1, A_SP_CTRL, 32'h0000_0001);
    apb(1, A_INT_LEN, 32'h0000_0014);
    sp_trig <= 1;
    @(posedge pclk);
    sp_trig <= 0;
    sp_i <= 16'sh0123;
    repeat (3) @(posedge pclk);
    sp_trig <= 1;
    @(posedge pclk);
    sp_trig <= 0;
    repeat (40) @(posedge pclk);
    rd(A_SP_ERR, 32'h0000_0001);
    rd(A_SP_ACQ, 32'h0000_0001);
    apb(1, A_SP_CLR, 32'h0000_0000);
    rd(A_SP_ERR, 32'h0000_0000);
    apb(1, A_ENV_LOAD, 32'h0000_0000);
    repeat (3) apb(1, A_ENV_WAVE, xs(seed));
    rd(A_ENV_LEN, 32'h0000_0003);
    apb(1, A_PSD_CLR, 32'h0000_0000);
    rd(A_PSD_OVF, 32'h0000_0000);
    osc_i <= 16'sh1357;
    repeat (3) @(posedge pclk);
    chk(32'(env_i), 32'(osc_i));
    apb(1, A_SP_CTRL, 32'h0000_0000);
    apb(1, A_INT_LEN, 32'h0000_0800);
    apb(1, A_SP_CTRL, 32'h0000_000D);
    sp_i <= 16'sh4000;
    sp_q <= 16'sh4000;
    sp_trig <= 1;
    @(posedge pclk);
    sp_trig <= 0;
    @(posedge pclk);
    @(negedge pclk);
    chk(32'(env_i), mod_re(osc_i, xs(seed)));
    repeat (2100) @(posedge pclk);
    rd(A_SP_DATA, psd_exp(2048, 16384));
    report_and_stop();
  end
endmodule // rslog_tb_top

/* File: rslog_top.sv */
// rslog_top: readout and spectroscopy result loggers with apb registers
//
// Implementation choices: the APB interface to the registers and the register addresses.

// ---------------------------------------------------------------
// averaging logger, one per result path
// ---------------------------------------------------------------
module rslog_avg (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire rslog_pkg::rslog_lcfg_t cfg,
  input wire logic clr,
  input wire logic trig,
  input wire logic res_vld,
  input wire logic [31:0] res_data,
  input wire logic [3:0] rd_idx,
  output logic [31:0] rd_data,
  output rslog_pkg::rslog_lsta_t sta,
  output logic start,
  output logic busy
);
  import rslog_pkg::*;
  logic [ACQ_W-1:0] acq_ff, avg_ff, job_ff, nxt_avg;
  logic [4:0] pt_ff, nxt_pt;
  logic [15:0] err_ff, nxt_err;
  logic wait_ff;
  logic [63:0] mem [PTS];

  wire [ACQ_W-1:0] avg_n = ACQ_W'(1) << cfg.avg_exp;
  wire [ACQ_W-1:0] total = ACQ_W'(cfg.len) << cfg.avg_exp;
  wire done = acq_ff >= total;
  wire take = trig & cfg.en & ~wait_ff & ~done;
  wire hold_err = trig & cfg.en & wait_ff;
  wire store = res_vld & wait_ff;
  wire pt_last = pt_ff == cfg.len - 5'h01;
  wire avg_last = avg_ff == avg_n - ACQ_W'(1);
  wire first = avg_ff == ACQ_W'(0);
  wire [63:0] cur = mem[pt_ff[3:0]];
  wire [31:0] in_i = {{16{res_data[31]}}, res_data[31:16]};
  wire [31:0] in_q = {{16{res_data[15]}}, res_data[15:0]};
  // first pass overwrites, later passes add: no separate clear sweep needed
  wire [31:0] add_i = (first ? 32'h0000_0000 : cur[63:32]) + in_i;
  wire [31:0] add_q = (first ? 32'h0000_0000 : cur[31:0]) + in_q;
  wire [4:0] pt_cyc = pt_last ? 5'h00 : pt_ff + 5'h01;
  wire [ACQ_W-1:0] avg_cyc = pt_last ? avg_ff + ACQ_W'(1) : avg_ff;
  wire [4:0] pt_seq = avg_last ? pt_ff + 5'h01 : pt_ff;
  wire [ACQ_W-1:0] avg_seq = avg_last ? ACQ_W'(0) : avg_ff + ACQ_W'(1);
  assign nxt_pt = cfg.mode ? pt_seq : pt_cyc;
  assign nxt_avg = cfg.mode ? avg_seq : avg_cyc;
  // set wins over clear so a coincident error is not lost
  assign nxt_err = hold_err ? (clr ? 16'h0001 : err_ff + 16'h0001)
                 : (clr ? 16'h0000 : err_ff);
  // readback divides the sum by the count; partial sums read low
  wire [63:0] rde = mem[rd_idx];
  wire signed [31:0] avg_i = $signed(rde[63:32]) >>> cfg.avg_exp;
  wire signed [31:0] avg_q = $signed(rde[31:0]) >>> cfg.avg_exp;
  assign rd_data = {avg_i[15:0], avg_q[15:0]};
  assign sta.acq = acq_ff;
  assign sta.err = err_ff;
  assign sta.job = job_ff;
  assign start = take;
  assign busy = wait_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acq_ff <= '0;
      avg_ff <= '0;
      pt_ff <= 5'h00;
      wait_ff <= 1'b0;
    end else if (ce && !cfg.en) begin
      acq_ff <= '0;
      avg_ff <= '0;
      pt_ff <= 5'h00;
      wait_ff <= 1'b0;
    end else if (ce) begin
      if (take) begin
        acq_ff <= acq_ff + ACQ_W'(1);
        wait_ff <= 1'b1;
      end else if (store) begin
        wait_ff <= 1'b0;
        pt_ff <= nxt_pt;
        avg_ff <= nxt_avg;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_ff <= 16'h0000;
      job_ff <= '0;
    end else if (ce) begin
      err_ff <= nxt_err;
      if (hold_err) begin
        job_ff <= acq_ff - ACQ_W'(1);
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (ce && store) begin
      mem[pt_ff[3:0]] <= {add_i, add_q};
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_CLR: assert property (ce && clr && !hold_err |=> err_ff == 16'h0000)
    else $error("error count not cleared");
  AST_CNT: assert property (ce && hold_err && !clr |=> err_ff == 16'($past(err_ff) + 16'h0001))
    else $error("hold-off error not counted");
  AST_JOB: assert property (ce && hold_err |=> job_ff == ACQ_W'($past(acq_ff) - ACQ_W'(1)))
    else $error("job index not captured");
  AST_DONE: assert property (ce && cfg.en && done |=> acq_ff == $past(acq_ff))
    else $error("acquisition past result length");
  AST_CYC: assert property (ce && cfg.en && store && !cfg.mode && !pt_last |=> pt_ff == 5'($past(pt_ff) + 5'h01))
    else $error("cyclic order did not advance point");
  AST_SEQ: assert property (ce && cfg.en && store && cfg.mode && !avg_last |=> pt_ff == $past(pt_ff))
    else $error("sequential order left point early");
  AST_ACQ: assert property (ce && take |=> acq_ff == ACQ_W'($past(acq_ff) + ACQ_W'(1)))
    else $error("acquisition index not advanced");
  AST_HOLD: assert property (ce && hold_err |=> acq_ff == $past(acq_ff) && wait_ff)
    else $error("trigger while busy started acquisition");
  AST_OFF: assert property (ce && !cfg.en |=> acq_ff == ACQ_W'(0) && !wait_ff)
    else $error("logger active while disabled");
endmodule // rslog_avg

// ---------------------------------------------------------------
// top: apb registers, readout path, spectroscopy path
// ---------------------------------------------------------------
module rslog_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ro_trig,
  input wire logic ro_vld,
  input wire logic [31:0] weighted_sum_source,
  input wire logic [31:0] state_decision_source,
  input wire logic dio_rdy,
  output logic dio_vld,
  output logic [31:0] dio_data,
  input wire logic sp_trig,
  input wire logic signed [15:0] sp_i,
  input wire logic signed [15:0] sp_q,
  input wire logic signed [15:0] osc_i,
  input wire logic signed [15:0] osc_q,
  output logic signed [15:0] env_i,
  output logic signed [15:0] env_q
);
  import rslog_pkg::*;
  rslog_lcfg_t ro_cfg_ff, sp_cfg_ff;
  rslog_lsta_t ro_sta, sp_sta;
  rslog_spst_t st_ff, nxt_st;
  logic [1:0] ro_src_ff;
  logic env_en_ff, psd_en_ff, psd_ovf_ff, hit_ff, hit, sp_vld_ff, dio_vld_ff;
  logic ro_busy, sp_start;
  logic [23:0] sp_dly_ff, env_dly_ff;
  logic [24:0] el_ff;
  logic [25:0] int_len_ff, ic_ff;
  logic [4:0] env_wp_ff, ei_ff;
  logic [15:0] ovd_ff;
  logic signed [40:0] ai_ff, aq_ff;
  logic [47:0] ap_ff;
  logic [31:0] prdata_ff, rd_val, ro_rd, sp_rd, dio_data_ff;
  logic signed [15:0] env_i_ff, env_q_ff;
  logic [31:0] env_mem [ENV_N];

  // ---------------------------------------------------------------
  // apb decode, zero wait states while enabled
  // ---------------------------------------------------------------
  wire wr = psel & penable & pwrite & ce;
  wire setup = psel & ~penable & ce;
  wire w_ro_clr = wr & (paddr == A_RO_CLR);
  wire w_sp_clr = wr & (paddr == A_SP_CLR);
  wire w_psd_clr = wr & (paddr == A_PSD_CLR);
  wire w_env_wave = wr & (paddr == A_ENV_WAVE);
  wire w_env_load = wr & (paddr == A_ENV_LOAD);
  wire in_ro_data = paddr[11:6] == A_RO_DATA[11:6];
  wire in_sp_data = paddr[11:6] == A_SP_DATA[11:6];
  wire [4:0] len_in = (pwdata[4:0] > PTS_MAX) ? PTS_MAX : pwdata[4:0];
  wire [25:0] il_raw = (pwdata[31:26] != 6'h00) ? INT_LEN_MAX : pwdata[25:0];
  wire [25:0] il_in = (il_raw == 26'h000_0000) ? INT_LEN_MIN
                    : ((il_raw > INT_LEN_MAX) ? INT_LEN_MAX : il_raw);
  assign pready = ce;
  assign pslverr = psel & penable & ~hit_ff;
  assign prdata = prdata_ff;

  always_comb begin
    rd_val = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      A_RO_CTRL: begin
        rd_val[F_EN] = ro_cfg_ff.en;
        rd_val[F_MODE] = ro_cfg_ff.mode;
        rd_val[F_SRC+:2] = ro_src_ff;
        rd_val[F_AVG+:4] = ro_cfg_ff.avg_exp;
      end
      A_SP_CTRL: begin
        rd_val[F_EN] = sp_cfg_ff.en;
        rd_val[F_MODE] = sp_cfg_ff.mode;
        rd_val[F_ENV] = env_en_ff;
        rd_val[F_PSD] = psd_en_ff;
        rd_val[F_AVG+:4] = sp_cfg_ff.avg_exp;
      end
      A_RO_LEN: rd_val = 32'(ro_cfg_ff.len);
      A_SP_LEN: rd_val = 32'(sp_cfg_ff.len);
      A_RO_ERR: rd_val = 32'(ro_sta.err);
      A_SP_ERR: rd_val = 32'(sp_sta.err);
      A_RO_JOB: rd_val = 32'(ro_sta.job);
      A_SP_JOB: rd_val = 32'(sp_sta.job);
      A_RO_ACQ: rd_val = 32'(ro_sta.acq);
      A_SP_ACQ: rd_val = 32'(sp_sta.acq);
      A_RO_OVD: rd_val = 32'(ovd_ff);
      A_SP_DLY: rd_val = 32'(sp_dly_ff);
      A_ENV_DLY: rd_val = 32'(env_dly_ff);
      A_INT_LEN: rd_val = 32'(int_len_ff);
      A_ENV_LEN: rd_val = 32'(env_wp_ff);
      A_PSD_OVF: rd_val[0] = psd_ovf_ff;
      A_RO_CLR, A_SP_CLR, A_PSD_CLR, A_ENV_WAVE, A_ENV_LOAD: rd_val = 32'h0000_0000;
      default: begin
        if (in_ro_data) begin
          rd_val = ro_rd;
        end else if (in_sp_data) begin
          rd_val = sp_rd;
        end else begin
          hit = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      hit_ff <= 1'b1;
    end else if (setup) begin
      prdata_ff <= pwrite ? 32'h0000_0000 : rd_val;
      hit_ff <= hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ro_cfg_ff <= '{en: 1'b0, mode: 1'b0, avg_exp: 4'h0, len: LEN_RST};
      sp_cfg_ff <= '{en: 1'b0, mode: 1'b0, avg_exp: 4'h0, len: LEN_RST};
      ro_src_ff <= SRC_WSUM;
      env_en_ff <= 1'b0;
      psd_en_ff <= 1'b0;
    end else if (wr) begin
      case (paddr)
        A_RO_CTRL: begin
          ro_cfg_ff.en <= pwdata[F_EN];
          ro_cfg_ff.mode <= pwdata[F_MODE];
          ro_cfg_ff.avg_exp <= pwdata[F_AVG+:4];
          ro_src_ff <= pwdata[F_SRC+:2];
        end
        A_SP_CTRL: begin
          sp_cfg_ff.en <= pwdata[F_EN];
          sp_cfg_ff.mode <= pwdata[F_MODE];
          sp_cfg_ff.avg_exp <= pwdata[F_AVG+:4];
          env_en_ff <= pwdata[F_ENV];
          psd_en_ff <= pwdata[F_PSD];
        end
        A_RO_LEN: ro_cfg_ff.len <= len_in;
        A_SP_LEN: sp_cfg_ff.len <= len_in;
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_dly_ff <= 24'h00_0000;
      env_dly_ff <= 24'h00_0000;
      int_len_ff <= INT_LEN_MIN;
    end else if (wr) begin
      if (paddr == A_SP_DLY) sp_dly_ff <= pwdata[23:0];
      if (paddr == A_ENV_DLY) env_dly_ff <= pwdata[23:0];
      if (paddr == A_INT_LEN) int_len_ff <= il_in;
    end
  end

  // ---------------------------------------------------------------
  // envelope store, filled word by word after a load restart
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      env_wp_ff <= 5'h00;
    end else if (w_env_load) begin
      env_wp_ff <= 5'h00;
    end else if (w_env_wave && env_wp_ff < PTS_MAX) begin
      env_wp_ff <= env_wp_ff + 5'h01;
    end
  end

  always_ff @(posedge pclk) begin
    if (w_env_wave && env_wp_ff < PTS_MAX) begin
      env_mem[env_wp_ff[3:0]] <= pwdata;
    end
  end

  // ---------------------------------------------------------------
  // readout path
  // ---------------------------------------------------------------
  wire [31:0] ro_res = (ro_src_ff == SRC_STATE) ? state_decision_source
                     : weighted_sum_source;
  wire ro_take = ro_vld & ro_busy;
  wire ovd_hit = ro_take & ~dio_rdy;

  rslog_avg u_ro (
    .pclk(pclk), .presetn(presetn), .ce(ce), .cfg(ro_cfg_ff), .clr(w_ro_clr),
    .trig(ro_trig), .res_vld(ro_vld), .res_data(ro_res), .rd_idx(paddr[5:2]),
    .rd_data(ro_rd), .sta(ro_sta), .start(), .busy(ro_busy)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovd_ff <= 16'h0000;
      dio_vld_ff <= 1'b0;
      dio_data_ff <= 32'h0000_0000;
    end else if (ce) begin
      dio_vld_ff <= ro_take & dio_rdy;
      if (ro_take && dio_rdy) dio_data_ff <= ro_res;
      if (ovd_hit) ovd_ff <= ovd_ff + 16'h0001;
    end
  end
  assign dio_vld = dio_vld_ff;
  assign dio_data = dio_data_ff;

  // ---------------------------------------------------------------
  // spectroscopy frame: delay, integrate, hand result to logger
  // ---------------------------------------------------------------
  wire in_frame = st_ff != SP_IDLE;
  wire int_go = el_ff >= {1'b0, sp_dly_ff};
  wire env_on = in_frame & (el_ff >= {1'b0, env_dly_ff}) & (ei_ff < env_wp_ff);
  wire int_end = (st_ff == SP_INT) & (ic_ff == int_len_ff - INT_LEN_MIN);
  wire signed [31:0] sq_i = sp_i * sp_i;
  wire signed [31:0] sq_q = sp_q * sp_q;
  wire [31:0] pw = 32'(sq_i) + 32'(sq_q);
  wire [48:0] psum = {1'b0, ap_ff} + 49'(pw);
  wire ovf_set = ce & (st_ff == SP_INT) & psd_en_ff & psum[48];
  wire [31:0] sp_res = psd_en_ff ? {16'h0000, ap_ff[47:32]}
                     : {ai_ff[40:25], aq_ff[40:25]};

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      SP_IDLE: if (sp_start) nxt_st = SP_DLY;
      SP_DLY: if (int_go) nxt_st = SP_INT;
      SP_INT: if (int_end) nxt_st = SP_IDLE;
      default: nxt_st = SP_IDLE;
    endcase
  end

  rslog_avg u_sp (
    .pclk(pclk), .presetn(presetn), .ce(ce), .cfg(sp_cfg_ff), .clr(w_sp_clr),
    .trig(sp_trig), .res_vld(sp_vld_ff), .res_data(sp_res), .rd_idx(paddr[5:2]),
    .rd_data(sp_rd), .sta(sp_sta), .start(sp_start), .busy()
  );

  // elapsed time saturates once past every settable delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= SP_IDLE;
      el_ff <= 25'h000_0000;
      ei_ff <= 5'h00;
      ic_ff <= 26'h000_0000;
      sp_vld_ff <= 1'b0;
    end else if (ce) begin
      st_ff <= nxt_st;
      sp_vld_ff <= int_end;
      if (sp_start) el_ff <= 25'h000_0000;
      else if (in_frame && !el_ff[24]) el_ff <= el_ff + DLY_STEP;
      if (sp_start) ei_ff <= 5'h00;
      else if (env_on) ei_ff <= ei_ff + 5'h01;
      if (st_ff != SP_INT) ic_ff <= 26'h000_0000;
      else ic_ff <= ic_ff + INT_LEN_MIN;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ai_ff <= '0;
      aq_ff <= '0;
      ap_ff <= 48'h0000_0000_0000;
    end else if (ce && sp_start) begin
      ai_ff <= '0;
      aq_ff <= '0;
      ap_ff <= 48'h0000_0000_0000;
    end else if (ce && st_ff == SP_INT) begin
      ai_ff <= ai_ff + 41'(sp_i);
      aq_ff <= aq_ff + 41'(sp_q);
      ap_ff <= psum[47:0];
    end
  end

  // set wins over clear so an overflow in the clear cycle stays visible
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psd_ovf_ff <= 1'b0;
    end else if (ovf_set) begin
      psd_ovf_ff <= 1'b1;
    end else if (w_psd_clr) begin
      psd_ovf_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // envelope modulation of the oscillator, q1.15 scaling
  // ---------------------------------------------------------------
  wire [31:0] ew = env_mem[ei_ff[3:0]];
  wire signed [15:0] e_re = ew[31:16];
  wire signed [15:0] e_im = ew[15:0];
  wire signed [32:0] m_re = 33'(osc_i * e_re) - 33'(osc_q * e_im);
  wire signed [32:0] m_im = 33'(osc_i * e_im) + 33'(osc_q * e_re);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      env_i_ff <= 16'sh0000;
      env_q_ff <= 16'sh0000;
    end else if (ce && !env_en_ff) begin
      env_i_ff <= osc_i;
      env_q_ff <= osc_q;
    end else if (ce) begin
      env_i_ff <= env_on ? m_re[30:15] : 16'sh0000;
      env_q_ff <= env_on ? m_im[30:15] : 16'sh0000;
    end
  end
  assign env_i = env_i_ff;
  assign env_q = env_q_ff;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_sp_go;
    ce && sp_start;
  endsequence
  sequence s_in_dly;
    st_ff == SP_DLY && el_ff == 25'h000_0000;
  endsequence
  AST_SP_DLY: assert property (s_sp_go |=> s_in_dly)
    else $error("frame did not enter delay phase");
  AST_PSD_OVF: assert property (ovf_set |=> psd_ovf_ff)
    else $error("power overflow not flagged");
  AST_PSD_CLR: assert property (w_psd_clr && !ovf_set |=> !psd_ovf_ff)
    else $error("power error flag not cleared");
  AST_ENV_OFF: assert property (ce && !env_en_ff |=> env_i == $past(osc_i))
    else $error("oscillator not passed with envelope off");
  AST_DIO: assert property (ce && ovd_hit |=> ovd_ff == 16'($past(ovd_ff) + 16'h0001))
    else $error("dio overflow not counted");
endmodule // rslog_top
